// ===== erp_pkg.sv
// Constants shared by the extended RAM indirect port files.
package erp_pkg;
  localparam int          BUS_AW         = 5;
  localparam int          DATA_W         = 8;
  localparam int          IDX_W          = 8;
  localparam int          RAM_DEPTH      = 256;
  localparam logic [4:0]  ADDR_LATCH_OFS = 5'h10;
  localparam logic [4:0]  DATA_WIN_OFS   = 5'h13;
  localparam logic [7:0]  IDX_RESET      = 8'h00;
  localparam logic [7:0]  IDX_STEP       = 8'h01;
  localparam logic [7:0]  DQ_RESET       = 8'h00;
endpackage : erp_pkg

// ===== erp_mem_if.sv
// Carrier between the bus port logic and the user RAM storage.
`timescale 1ns/100ps
interface erp_mem_if #(parameter int IDX_W = 8, parameter int DATA_W = 8);
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [IDX_W-1:0]  rd_idx;
  logic [DATA_W-1:0] rd_data;
  modport port_side (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem_side  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : erp_mem_if

// ===== erp_user_ram.sv
// Battery-backed user RAM storage, flip-flops addressed by index.
`timescale 1ns/100ps
module erp_user_ram #(
  parameter int DEPTH  = 256,
  parameter int IDX_W  = 8,
  parameter int DATA_W = 8
) (
  input  wire logic  clock_i,
  input  wire logic  ce_i,
  erp_mem_if.mem_side mem
);
  logic [DATA_W-1:0] store_reg [DEPTH];
  logic [DATA_W-1:0] store_next [DEPTH];

  // Contents have no reset: the storage is nonvolatile across resets.
  always_comb
  begin
    store_next = store_reg;
    if (ce_i && mem.wr_en)
    begin
      store_next[mem.wr_idx] = mem.wr_data;  // [RULE1]
    end
  end

  always_ff @(posedge clock_i)
  begin
    store_reg <= store_next;
  end

  assign mem.rd_data = store_reg[mem.rd_idx];
endmodule : erp_user_ram

// ===== erp_ram_port.sv
// Indirect access port to the 256-byte user RAM on the bytewide bus.
`timescale 1ns/100ps
// Operation
// RULE1: Hold 256 user bytes, eight bits each.
// RULE2: Release write protection right after power-up.
// RULE3: Eight-bit index covers locations 00h to FFh.
// RULE4: Host loads index at location 10h first.
// RULE5: Read at 13h returns byte at index.
// RULE6: Write at 13h stores byte at index.
// RULE7: Without burst, index stays unchanged between accesses.
// RULE8: Host sets burst enable bit for increments.
// RULE9: Burst: load start index, then access 13h.
// RULE10: Burst increments index on strobe rising edge.
// RULE11: Index wraps FFh to 00h; others untouched.
module erp_ram_port
  import erp_pkg::*;
(
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  input  wire logic                      ce_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      oe_n_i,
  input  wire logic                      we_n_i,
  input  wire logic [erp_pkg::BUS_AW-1:0] addr_i,
  input  wire logic [erp_pkg::DATA_W-1:0] dq_i,
  input  wire logic                      burst_increment_enable_i,
  output logic      [erp_pkg::DATA_W-1:0] dq_o,
  output logic                           dq_oe_o,
  output logic      [erp_pkg::IDX_W-1:0]  ram_index_o
);
  import erp_pkg::*;

  function automatic logic is_ofs(input logic [BUS_AW-1:0] a, input logic [BUS_AW-1:0] ofs);
    is_ofs = (a == ofs);
  endfunction : is_ofs

  erp_mem_if #(.IDX_W(IDX_W), .DATA_W(DATA_W)) mif ();

  erp_user_ram #(.DEPTH(RAM_DEPTH), .IDX_W(IDX_W), .DATA_W(DATA_W)) u_ram (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .mem     (mif.mem_side)
  );

  logic              act_now;
  logic              act_reg,  act_next;
  logic              wr_reg,   wr_next;
  logic [BUS_AW-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dqin_reg, dqin_next;
  logic [IDX_W-1:0]  idx_reg,  idx_next;
  logic              wp_reg,   wp_next;
  logic [DATA_W-1:0] dq_reg,   dq_next;
  logic              oe_reg,   oe_next;
  logic              end_evt;
  logic              mem_wr;

  // An access lasts while the chip is selected and either strobe is low.
  assign act_now = !cs_n_i && (!oe_n_i || !we_n_i);
  // The access closes when chip select or the last low strobe rises.
  assign end_evt = ce_i && act_reg && !act_now;
  assign mem_wr  = end_evt && wr_reg && !wp_reg && is_ofs(addr_reg, DATA_WIN_OFS);

  assign mif.wr_en   = mem_wr;  // [RULE6]
  assign mif.wr_idx  = idx_reg;
  assign mif.wr_data = dqin_reg;
  assign mif.rd_idx  = idx_reg;  // [RULE5]

  always_comb
  begin
    act_next  = act_reg;
    wr_next   = wr_reg;
    addr_next = addr_reg;
    dqin_next = dqin_reg;
    idx_next  = idx_reg;
    wp_next   = wp_reg;
    dq_next   = dq_reg;
    oe_next   = oe_reg;
    if (ce_i)
    begin
      wp_next  = 1'b0;  // [RULE2]
      act_next = act_now;
      oe_next  = 1'b0;
      if (act_now)
      begin
        wr_next   = !we_n_i;
        addr_next = addr_i;
        dqin_next = dq_i;
        if (we_n_i && !oe_n_i)
        begin
          if (is_ofs(addr_i, DATA_WIN_OFS))
          begin
            dq_next = mif.rd_data;  // [RULE5]
            oe_next = 1'b1;
          end
          else if (is_ofs(addr_i, ADDR_LATCH_OFS))
          begin
            dq_next = idx_reg;
            oe_next = 1'b1;
          end
        end
      end
      if (end_evt)
      begin
        if (wr_reg && is_ofs(addr_reg, ADDR_LATCH_OFS))
        begin
          idx_next = dqin_reg;  // [RULE3] [RULE4]
        end
        else if (burst_increment_enable_i && is_ofs(addr_reg, DATA_WIN_OFS))
        begin
          idx_next = IDX_W'(idx_reg + IDX_STEP);  // [RULE10] [RULE11] [RULE8] [RULE9]
        end
        // Any other end of access leaves the index alone.  [RULE7]
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      act_reg  <= 1'b0;
      wr_reg   <= 1'b0;
      addr_reg <= '0;
      dqin_reg <= '0;
      idx_reg  <= IDX_RESET;
      wp_reg   <= 1'b1;
      dq_reg   <= DQ_RESET;
      oe_reg   <= 1'b0;
    end
    else
    begin
      act_reg  <= act_next;
      wr_reg   <= wr_next;
      addr_reg <= addr_next;
      dqin_reg <= dqin_next;
      idx_reg  <= idx_next;
      wp_reg   <= wp_next;
      dq_reg   <= dq_next;
      oe_reg   <= oe_next;
    end
  end

  assign dq_o        = dq_reg;
  assign dq_oe_o     = oe_reg;
  assign ram_index_o = idx_reg;

  property p_wp_release;
    @(posedge clock_i) disable iff (reset_i)
    ce_i |=> !wp_reg;
  endproperty
  a_wp_release: assert property (p_wp_release) else $error("write protect not released"); // [RULE2]

  property p_latch_load;
    @(posedge clock_i) disable iff (reset_i)
    end_evt && wr_reg && is_ofs(addr_reg, ADDR_LATCH_OFS) |=> ram_index_o == $past(dqin_reg);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("index not loaded from bus"); // [RULE4]

  property p_burst_inc;
    @(posedge clock_i) disable iff (reset_i)
    end_evt && burst_increment_enable_i && !wr_reg && is_ofs(addr_reg, DATA_WIN_OFS)
    |=> ram_index_o == IDX_W'($past(idx_reg) + IDX_STEP);
  endproperty
  a_burst_inc: assert property (p_burst_inc) else $error("burst did not advance index"); // [RULE10]

  property p_wrap;
    @(posedge clock_i) disable iff (reset_i)
    end_evt && burst_increment_enable_i && is_ofs(addr_reg, DATA_WIN_OFS) && idx_reg == '1
    |=> ram_index_o == IDX_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("index did not wrap"); // [RULE11]

  property p_hold;
    @(posedge clock_i) disable iff (reset_i)
    !(end_evt && wr_reg && is_ofs(addr_reg, ADDR_LATCH_OFS))
    && !(end_evt && burst_increment_enable_i && is_ofs(addr_reg, DATA_WIN_OFS))
    |=> $stable(ram_index_o);
  endproperty
  a_hold: assert property (p_hold) else $error("index changed unexpectedly"); // [RULE7]

  property p_write;
    @(posedge clock_i) disable iff (reset_i)
    end_evt && wr_reg && is_ofs(addr_reg, DATA_WIN_OFS) && !wp_reg
    |-> mif.wr_en && mif.wr_idx == idx_reg && mif.wr_data == dqin_reg;
  endproperty
  a_write: assert property (p_write) else $error("data window write lost"); // [RULE6]

  property p_read;
    @(posedge clock_i) disable iff (reset_i)
    ce_i && act_now && we_n_i && !oe_n_i && is_ofs(addr_i, DATA_WIN_OFS)
    |=> dq_oe_o && dq_o == $past(mif.rd_data);
  endproperty
  a_read: assert property (p_read) else $error("data window read wrong"); // [RULE5]

  property p_store;
    @(posedge clock_i) disable iff (reset_i)
    mem_wr |=> mif.rd_idx != $past(idx_reg) || mif.rd_data == $past(dqin_reg);
  endproperty
  a_store: assert property (p_store) else $error("ram did not keep byte"); // [RULE1]

  // A low clock enable must freeze every visible output of the port.
  property p_ce_freeze;
    @(posedge clock_i) disable iff (reset_i)
    !ce_i |=> $stable(ram_index_o) && $stable(dq_o) && $stable(dq_oe_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low"); // [RULE7]

  property p_other_ofs;
    @(posedge clock_i) disable iff (reset_i)
    ce_i && act_now && !is_ofs(addr_i, DATA_WIN_OFS) && !is_ofs(addr_i, ADDR_LATCH_OFS) |=> !dq_oe_o;
  endproperty
  a_other_ofs: assert property (p_other_ofs) else $error("unmapped location drove the bus"); // [RULE11]

  c_burst_read: cover property (@(posedge clock_i) disable iff (reset_i)
    end_evt && !wr_reg && burst_increment_enable_i && is_ofs(addr_reg, DATA_WIN_OFS));
  c_burst_write: cover property (@(posedge clock_i) disable iff (reset_i)
    mem_wr && burst_increment_enable_i);
  c_wrap: cover property (@(posedge clock_i) disable iff (reset_i)
    end_evt && burst_increment_enable_i && is_ofs(addr_reg, DATA_WIN_OFS) && idx_reg == '1);
  c_ce_hold: cover property (@(posedge clock_i) disable iff (reset_i)
    !ce_i && act_now);
  c_latch: cover property (@(posedge clock_i) disable iff (reset_i)
    end_evt && wr_reg && is_ofs(addr_reg, ADDR_LATCH_OFS));
endmodule : erp_ram_port

// ===== erp_host_model.sv
// Host processor model that drives the bytewide bus of the RAM port.
`timescale 1ns/100ps
module erp_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       dq_oe_i,
  output logic            cs_n_o,
  output logic            oe_n_o,
  output logic            we_n_o,
  output logic      [4:0] addr_o,
  output logic      [7:0] dq_o,
  output logic            burst_o
);
  initial
  begin
    {cs_n_o, oe_n_o, we_n_o, burst_o} = 4'hE;
    addr_o = 5'h1F;
    dq_o   = 8'h00;
  end
  // One sampled active cycle, then at least one idle cycle before the next access.
  task bus_op(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    oe_n_o <= wr;
    we_n_o <= !wr;
    addr_o <= a;
    dq_o   <= d;
    @(posedge clock_i);
    {cs_n_o, oe_n_o, we_n_o} <= 3'h7;
    // Released lines show the inverse so that a stale value cannot pass.
    addr_o <= ~a;
    dq_o   <= ~d;
    #1;
    q  = dq_i;
    oe = dq_oe_i;
    // Let the access end so that index and RAM effects are visible on return.
    @(posedge clock_i);
    #1;
  endtask : bus_op
  task set_burst(input logic en);
    @(posedge clock_i);
    burst_o <= en;
  endtask : set_burst
endmodule : erp_host_model

// ===== erp_ram_port_tb_top.sv
// Self-checking testbench of the extended RAM indirect port.
`timescale 1ns/100ps
module erp_ram_port_tb_top;
  import erp_pkg::*;
  typedef struct packed {logic wr; logic [4:0] a; logic [7:0] d; logic [7:0] q;} erp_row_t;
  logic       clock_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       ce = 1'b1;
  logic       cs_n, oe_n, we_n, burst, dq_oe, oe;
  logic [4:0] addr;
  logic [7:0] dq_h, dq_d, idx, q, ex;
  int         num_errors = 0;
  int         compares = 0;
  erp_row_t   rows [8] = '{'{1, 5'h10, 8'h05, 8'h00}, '{1, 5'h13, 8'hAA, 8'h00}, '{0, 5'h13, 8'h00, 8'hAA},
    '{0, 5'h13, 8'h00, 8'hAA}, '{0, 5'h10, 8'h00, 8'h05}, '{1, 5'h10, 8'hFF, 8'h00},
    '{1, 5'h13, 8'h5C, 8'h00}, '{0, 5'h13, 8'h00, 8'h5C}};
  erp_host_model erp_host_model_i (.clock_i(clock_i), .dq_i(dq_d), .dq_oe_i(dq_oe), .cs_n_o(cs_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .dq_o(dq_h), .burst_o(burst));
  erp_ram_port erp_ram_port_i (.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce), .cs_n_i(cs_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .dq_i(dq_h), .burst_increment_enable_i(burst),
    .dq_o(dq_d), .dq_oe_o(dq_oe), .ram_index_o(idx));
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    #40000;
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    ex = 8'h00;
    foreach (rows[i])
    begin
      erp_host_model_i.bus_op(rows[i].wr, rows[i].a, rows[i].d, q, oe);
      if (rows[i].wr && rows[i].a == 5'h10)
        ex = rows[i].d;
      if (!rows[i].wr)
        check(q, rows[i].q);
      check(idx, ex);
    end
    $display("Test single accesses done");
    erp_host_model_i.set_burst(1'b1);
    erp_host_model_i.bus_op(1'b1, 5'h10, 8'hFE, q, oe);
    for (int i = 1; i < 4; i++)
      erp_host_model_i.bus_op(1'b1, 5'h13, 8'(8'h11 * i), q, oe);
    check(idx, 8'h01);
    erp_host_model_i.bus_op(1'b0, 5'h11, 8'h00, q, oe);
    check({7'h00, oe}, 8'h00);
    check(idx, 8'h01);
    erp_host_model_i.bus_op(1'b1, 5'h10, 8'hFE, q, oe);
    for (int i = 1; i < 4; i++)
    begin
      erp_host_model_i.bus_op(1'b0, 5'h13, 8'h00, q, oe);
      check(q, 8'(8'h11 * i));
    end
    check(idx, 8'h01);
    $display("Test burst wrap done");
    erp_host_model_i.set_burst(1'b0);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    #1;
    check(idx, 8'h00);
    check({7'h00, dq_oe}, 8'h00);
    @(posedge clock_i);
    erp_host_model_i.bus_op(1'b1, 5'h10, 8'h20, q, oe);
    erp_host_model_i.bus_op(1'b1, 5'h13, 8'h9D, q, oe);
    erp_host_model_i.bus_op(1'b0, 5'h13, 8'h00, q, oe);
    check(q, 8'h9D);
    $display("Test reset and protect done");
    @(posedge clock_i);
    ce <= 1'b0;
    erp_host_model_i.bus_op(1'b1, 5'h10, 8'h44, q, oe);
    erp_host_model_i.bus_op(1'b1, 5'h13, 8'h66, q, oe);
    @(posedge clock_i);
    ce <= 1'b1;
    erp_host_model_i.bus_op(1'b0, 5'h13, 8'h00, q, oe);
    check(q, 8'h9D);
    check(idx, 8'h20);
    $display("Test clock enable freeze done");
    close_out();
  end
endmodule : erp_ram_port_tb_top
